// >>> mcu_interrupt_controller_bench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) chk(64'(a), 64'(b))
module mcu_interrupt_controller_bench
	import mic_pkg::*;
;
	logic clk, rstn, return_from_irq, rtc, gpio, hit, pdn, whigh;
	mic_sfr_t sfr;
	mic_cpu_t cpu;
	mic_irq_t irq;
	mic_src_t wsrc;
	logic [7:0] ben, bpr, rd;
	logic [1:0] etype, pin_n, pend, isv;
	logic [3:0] pflag, evt;
	int n_mismatch, comparisons, cyc, lat;
	mic_cpu_model cpu_u(.i_clk(clk), .i_rstn(rstn), .i_return_from_irq(return_from_irq),
		.o_cpu(cpu));
	mic_irq_ctrl dut_u(.I_CLK(clk), .I_RSTN(rstn), .I_SFR(sfr),
		.I_CPU(cpu), .I_BASE_EN(ben), .I_BASE_PRIO(bpr),
		.I_EXT_TYPE(etype), .I_EXT_IRQ_PIN_N(pin_n),
		.I_PERIPH_FLAG(pflag), .I_EVT_SRC(evt), .I_RTC_WAKE(rtc),
		.I_GPIO_WAKE(gpio), .O_IRQ(irq), .O_SFR_RDATA(rd),
		.O_SFR_HIT(hit), .O_EXT_PENDING(pend), .O_IN_SERVICE(isv),
		.O_POWER_DOWN(pdn));
	task automatic wrap_up();
		$display("counts: %0d mismatches, %0d comparisons",
			n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] a, input logic [63:0] b);
		comparisons++;
		if (a !== b)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got %0h exp %0h", $time, a, b);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		tick(4);
		rstn = 1'b1;
		tick(3);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr = '{addr: a, wr: 1'b1, wdata: d};
		tick(1);
		sfr.wr = 1'b0;
		// let an edge pass so a following write raises the strobe cleanly
		tick(1);
	endtask
	// expected {hit, data}; read data trails the address by one cycle
	task automatic rdchk(input logic [7:0] a, input logic [8:0] e);
		sfr.addr = a;
		tick(1);
		`CHK({hit, rd}, e);
	endtask
	// req is combinational, so it is looked at mid-cycle
	task automatic wait_req(output logic got);
		got = 1'b0;
		lat = 0;
		repeat (80)
		begin
			@(negedge clk);
			lat++;
			if (irq.req === 1'b1)
			begin
				got = 1'b1;
				wsrc = irq.src;
				whigh = irq.high;
				break;
			end
		end
		tick(1);
	endtask
	function automatic mic_src_t pick(input logic [10:0] rq,
		input logic [10:0] hi);
		for (int i = 0; i < NUM_SRC; i++)
			if (rq[i] && hi[i])
				return mic_src_t'(i);
		for (int i = 0; i < NUM_SRC; i++)
			if (rq[i])
				return mic_src_t'(i);
		return SRC_EXT0;
	endfunction
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial
	begin
		logic g;
		logic b;
		logic [3:0] m, p;
		logic [7:0] d;
		sfr = '0;
		return_from_irq = 1'b0;
		rtc = 1'b0;
		gpio = 1'b0;
		ben = 8'h00;
		bpr = 8'h00;
		etype = 2'h0;
		pin_n = 2'h3;
		pflag = 4'h0;
		evt = 4'h0;
		n_mismatch = 0;
		comparisons = 0;
		cyc = 0;
		void'($urandom(32'h589e65fe));
		do_reset();
		rdchk(ADDR_EXT_EN, 9'h1e0);
		rdchk(ADDR_EXT_PRIO, 9'h1e0);
		rdchk(ADDR_BASE_EN, 9'h000);
		rdchk(8'h55, 9'h000);
		repeat (4)
		begin
			d = 8'($urandom);
			wr(ADDR_EXT_EN, d);
			rdchk(ADDR_EXT_EN, {4'hf, d[4:0]});
			wr(ADDR_EXT_PRIO, ~d);
			rdchk(ADDR_EXT_PRIO, {4'hf, ~d[4:0]});
		end
		$display("test registers done");
		repeat (6)
		begin
			do_reset();
			m = 4'($urandom);
			p = 4'($urandom);
			b = 1'($urandom);
			bpr = {6'h0, b, 1'b0};
			pflag = 4'h1;
			ben = 8'h02;
			wr(ADDR_EXT_EN, 8'h0f);
			wr(ADDR_EXT_PRIO, {4'h0, p});
			evt = m;
			tick(2);
			rdchk(ADDR_EXT_FLAG, {1'b1, m, 4'h8});
			wait_req(g);
			`CHK(g, 1'b0);
			ben = 8'h82;
			wait_req(g);
			`CHK({g, whigh, wsrc}, {1'b1, b | (|(m & p)), pick({1'b0, m,
				6'h02}, {1'b0, p, 4'h0, b, 1'b0})});
			wr(ADDR_EXT_FLAG, {~m, 4'h0});
			rdchk(ADDR_EXT_FLAG, {1'b1, ~m, 4'h8});
			evt = 4'h0;
			pflag = 4'h0;
		end
		$display("test arbitration done");
		do_reset();
		etype = 2'h1;
		// pin high since reset, then held low well past four clocks
		pin_n[0] = 1'b0;
		tick(16);
		`CHK(pend[0], 1'b1);
		ben = 8'h81;
		wait_req(g);
		`CHK({g, wsrc}, {1'b1, SRC_EXT0});
		`CHK(lat <= MAX_RESPONSE_CLKS, 1'b1);
		`CHK({pend[0], isv}, 3'h1);
		pin_n[1] = 1'b0;
		tick(16);
		`CHK(pend[1], 1'b1);
		ben = 8'h85;
		wait_req(g);
		`CHK(g, 1'b0);
		bpr = 8'h04;
		wait_req(g);
		`CHK({g, whigh, wsrc, isv}, {2'h3, SRC_EXT1, 2'h3});
		pin_n[1] = 1'b1;
		tick(16);
		`CHK(pend[1], 1'b0);
		return_from_irq = 1'b1;
		tick(4);
		return_from_irq = 1'b0;
		tick(2);
		`CHK(isv, 2'h1);
		$display("test pins and service done");
		do_reset();
		rtc = 1'b1;
		tick(1);
		rtc = 1'b0;
		tick(1);
		rdchk(ADDR_EXT_CTRL, 9'h148);
		ben = 8'h80;
		wait_req(g);
		`CHK(g, 1'b0);
		wr(ADDR_EXT_EN, 8'h10);
		wait_req(g);
		`CHK({g, wsrc}, {1'b1, SRC_WAKEUP});
		wr(ADDR_EXT_CTRL, 8'h00);
		rdchk(ADDR_EXT_CTRL, 9'h140);
		wr(ADDR_CLK_CTRL, 8'h01);
		tick(1);
		`CHK(pdn, 1'b1);
		gpio = 1'b1;
		tick(1);
		gpio = 1'b0;
		tick(STARTUP_CYCLES - 1);
		`CHK(pdn, 1'b1);
		tick(1);
		`CHK(pdn, 1'b0);
		$display("test wakeup done");
		wrap_up();
	end
endmodule

// >>> mic_cpu_model.sv
// cpu stand-in: instruction boundaries every four clocks
`timescale 1ns/1ps
module mic_cpu_model
	import mic_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_return_from_irq,
	output mic_cpu_t o_cpu
);
	logic [1:0] cnt;
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt <= 2'h0;
			o_cpu <= '0;
		end
		else
		begin
			cnt <= cnt + 2'h1;
			// service may only start on this boundary pulse
			o_cpu.instr_end <= #2 (cnt == 2'h2);
			o_cpu.is_return_from_irq <= #2 i_return_from_irq;
		end
	end
endmodule

// >>> mic_irq_ctrl.sv
// interrupt controller: extended enables, priorities, arbitration
`timescale 1ns/1ps
module mic_irq_ctrl
	import mic_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire mic_sfr_t I_SFR,
	input wire mic_cpu_t I_CPU,
	input wire logic [7:0] I_BASE_EN,
	input wire logic [7:0] I_BASE_PRIO,
	input wire logic [1:0] I_EXT_TYPE,
	input wire logic [1:0] I_EXT_IRQ_PIN_N,
	input wire logic [3:0] I_PERIPH_FLAG,
	input wire logic [3:0] I_EVT_SRC,
	input wire logic I_RTC_WAKE,
	input wire logic I_GPIO_WAKE,
	output mic_irq_t O_IRQ,
	output logic [7:0] O_SFR_RDATA,
	output logic O_SFR_HIT,
	output logic [1:0] O_EXT_PENDING,
	output logic [1:0] O_IN_SERVICE,
	output logic O_POWER_DOWN
);
	mic_ctl_state_t st;
	mic_ctl_state_t next_st;
	logic fourth_clock_phase;
	logic [1:0] ext_evt;
	logic [1:0] ext_low;
	logic [1:0] ext_pending;
	logic [NUM_SRC-1:0] flags;
	logic [NUM_SRC-1:0] enables;
	logic [NUM_SRC-1:0] prios;
	logic [NUM_SRC-1:0] active;
	logic [NUM_SRC-1:0] hi_req;
	logic [NUM_SRC-1:0] lo_req;
	logic wr_ext_en;
	logic wr_ext_prio;
	logic wr_flag;
	logic wr_ctrl;
	logic wr_clk;
	logic wr_irq_sfr;
	logic hold;
	logic slot_free;
	logic take;
	logic wake;

	function automatic logic is_wr(input mic_sfr_t s, input logic [7:0] a);
		return s.wr && s.addr == a;
	endfunction

	// lowest index wins inside one level
	function automatic mic_src_t first_set(input logic [NUM_SRC-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (v[i])
				idx = 4'(i);
		end
		return mic_src_t'(idx);
	endfunction

	// the divider marks the last clock of each instruction cycle
	assign fourth_clock_phase = st.phase == LAST_PHASE;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			mic_pin_sampler u_smp (
				.i_clk(I_CLK),
				.i_rstn(I_RSTN),
				.i_pin_n(I_EXT_IRQ_PIN_N[g]),
				.i_sample(fourth_clock_phase),
				.i_edge_mode(I_EXT_TYPE[g]),
				.o_event(ext_evt[g]),
				.o_low(ext_low[g])
			);
			// level mode follows the pin sample; no capture is kept
			assign ext_pending[g] = I_EXT_TYPE[g] ? st.edge_pend[g]
				: ext_low[g];
		end
	endgenerate

	assign wr_ext_en = is_wr(I_SFR, ADDR_EXT_EN);
	assign wr_ext_prio = is_wr(I_SFR, ADDR_EXT_PRIO);
	assign wr_flag = is_wr(I_SFR, ADDR_EXT_FLAG);
	assign wr_ctrl = is_wr(I_SFR, ADDR_EXT_CTRL);
	assign wr_clk = is_wr(I_SFR, ADDR_CLK_CTRL);
	assign wr_irq_sfr = wr_ext_en | wr_ext_prio
		| is_wr(I_SFR, ADDR_BASE_EN) | is_wr(I_SFR, ADDR_BASE_PRIO);
	assign wake = I_RTC_WAKE | I_GPIO_WAKE;

	// natural order: ext0, tmr0, ext1, tmr1, serial, tmr2, int2..5, wakeup
	assign flags = {st.wake_flag, st.flag, I_PERIPH_FLAG[3:2],
		I_PERIPH_FLAG[1], ext_pending[1], I_PERIPH_FLAG[0],
		ext_pending[0]};
	assign enables = {st.ext_en, I_BASE_EN[NUM_BASE-1:0]}
		& {NUM_SRC{I_BASE_EN[GLOBAL_EN_POS]}};
	assign prios = {st.ext_prio, I_BASE_PRIO[NUM_BASE-1:0]};
	assign active = flags & enables;
	assign hi_req = active & prios;
	assign lo_req = active & ~prios;

	// one more instruction after a return or an enable/priority write
	assign hold = I_CPU.is_return_from_irq | st.sfr_hold | wr_irq_sfr;
	assign slot_free = st.win_high ? !st.in_high
		: !st.in_high && !st.in_low;
	// only at an instruction boundary, so the current one finishes
	assign take = I_CPU.instr_end && st.win_valid && slot_free && !hold
		&& !st.power_down && I_BASE_EN[GLOBAL_EN_POS];

	always_comb
	begin
		next_st = st;
		next_st.phase = st.phase + 2'h1;
		next_st.src_prev = I_EVT_SRC;

		if (wr_ext_en)
			next_st.ext_en = I_SFR.wdata[4:0];
		if (wr_ext_prio)
			next_st.ext_prio = I_SFR.wdata[4:0];

		// hardware sets win over a software clear in the same cycle
		if (wr_flag)
			next_st.flag = I_SFR.wdata[7:FLAG_LO_POS];
		next_st.flag = next_st.flag | (I_EVT_SRC & ~st.src_prev);
		if (wr_ctrl)
			next_st.wake_flag = I_SFR.wdata[WAKE_FLAG_POS];
		if (wake)
			next_st.wake_flag = 1'b1;

		for (int i = 0; i < 2; i++)
		begin
			if (take && O_IRQ.src == mic_src_t'(4'(2 * i)))
				next_st.edge_pend[i] = 1'b0;
			if (!I_EXT_TYPE[i])
				next_st.edge_pend[i] = 1'b0;
			else if (ext_evt[i])
				next_st.edge_pend[i] = 1'b1;
		end

		if (I_CPU.instr_end)
			next_st.sfr_hold = wr_irq_sfr;
		else if (wr_irq_sfr)
			next_st.sfr_hold = 1'b1;

		// priority level first, natural order second
		next_st.win_valid = 1'b0;
		next_st.win_high = 1'b0;
		next_st.win_src = first_set(lo_req);
		if (|hi_req)
		begin
			next_st.win_valid = 1'b1;
			next_st.win_high = 1'b1;
			next_st.win_src = first_set(hi_req);
		end
		else if (|lo_req)
			next_st.win_valid = 1'b1;

		if (take)
		begin
			if (st.win_high)
				next_st.in_high = 1'b1;
			else
				next_st.in_low = 1'b1;
		end
		else if (I_CPU.instr_end && I_CPU.is_return_from_irq)
		begin
			// the innermost routine is the high one when both run
			if (st.in_high)
				next_st.in_high = 1'b0;
			else
				next_st.in_low = 1'b0;
		end

		if (wr_clk && I_SFR.wdata != 8'h00)
			next_st.power_down = 1'b1;
		if (st.power_down && !st.waking && wake)
		begin
			next_st.waking = 1'b1;
			next_st.start_cnt = STARTUP_W'(STARTUP_CYCLES - 1);
		end
		if (st.waking)
		begin
			// regulator and clock start time delays the wakeup service
			if (st.start_cnt == '0)
			begin
				next_st.waking = 1'b0;
				next_st.power_down = 1'b0;
			end
			else
				next_st.start_cnt = st.start_cnt - STARTUP_W'(1);
		end

		next_st.rhit = 1'b1;
		unique case (I_SFR.addr)
			ADDR_EXT_EN:
				next_st.rdata = {RSVD_ONES, st.ext_en};
			ADDR_EXT_PRIO:
				next_st.rdata = {RSVD_ONES, st.ext_prio};
			ADDR_EXT_FLAG:
				next_st.rdata = {st.flag, 4'h0}
					| 8'(1 << FLAG_ONE_POS);
			ADDR_EXT_CTRL:
			begin
				next_st.rdata = 8'h00;
				next_st.rdata[WAKE_FLAG_POS] = st.wake_flag;
				next_st.rdata[CTRL_ONE_POS] = 1'b1;
			end
			default:
			begin
				next_st.rdata = 8'h00;
				next_st.rhit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			st <= CTL_RESET;
		else
			st <= next_st;
	end

	assign O_IRQ.req = take;
	assign O_IRQ.high = st.win_high;
	assign O_IRQ.src = st.win_src;
	assign O_SFR_RDATA = st.rdata;
	assign O_SFR_HIT = st.rhit;
	assign O_EXT_PENDING = ext_pending;
	assign O_IN_SERVICE = {st.in_high, st.in_low};
	assign O_POWER_DOWN = st.power_down;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);

	a_eie_reserved: assert property (
		I_SFR.addr == ADDR_EXT_EN |=> O_SFR_RDATA[7:5] == RSVD_ONES)
		else $error("enable reserved bits not read as ones");

	a_eip_reserved: assert property (
		I_SFR.addr == ADDR_EXT_PRIO |=> O_SFR_RDATA[7:5] == RSVD_ONES)
		else $error("priority reserved bits not read as ones");

	a_global_mask: assert property (
		!I_BASE_EN[GLOBAL_EN_POS] |-> !O_IRQ.req)
		else $error("request issued while globally masked");

	a_high_no_preempt: assert property (
		st.in_high |-> !O_IRQ.req)
		else $error("high level routine was preempted");

	a_low_preempt_high: assert property (
		O_IRQ.req && st.in_low |-> O_IRQ.high)
		else $error("low routine preempted by a low request");

	a_return_from_irq_hold: assert property (
		I_CPU.instr_end && I_CPU.is_return_from_irq |-> !O_IRQ.req)
		else $error("service began right after a return");

	a_phase_period: assert property (
		fourth_clock_phase |=> !fourth_clock_phase [*3]
		##1 fourth_clock_phase)
		else $error("sample enable not every four clocks");

	a_flag_sticky: assert property (
		st.flag[0] && !wr_flag |=> st.flag[0])
		else $error("source flag cleared without software");

	a_flag_rise: assert property (
		I_EVT_SRC[3] && !st.src_prev[3] |=> st.flag[3])
		else $error("rising source edge did not set its flag");

	a_wake_set: assert property (
		I_RTC_WAKE || I_GPIO_WAKE |=> st.wake_flag)
		else $error("wakeup event did not set the wakeup flag");

	a_pd_enter: assert property (
		wr_clk && I_SFR.wdata != 8'h00 |=> O_POWER_DOWN)
		else $error("non-zero clock control write missed power-down");

	a_pd_no_req: assert property (
		O_POWER_DOWN |-> !O_IRQ.req)
		else $error("request issued during power-down");

	a_edge_clear: assert property (
		O_IRQ.req && O_IRQ.src == SRC_EXT0 && I_EXT_TYPE[0]
		&& !ext_evt[0] |=> !st.edge_pend[0])
		else $error("edge pending not cleared on vectoring");
endmodule

// >>> mic_pin_sampler.sv
// external interrupt pin synchroniser and per-instruction sampler
`timescale 1ns/1ps
module mic_pin_sampler
	import mic_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_pin_n,
	input wire logic i_sample,
	input wire logic i_edge_mode,
	output logic o_event,
	output logic o_low
);
	mic_smp_state_t st;
	mic_smp_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.sync = {st.sync[1:0], i_pin_n};
		// a change is believed only once the two later stages agree
		if (st.sync[2] == st.sync[1])
			next_st.stable = st.sync[2];
		next_st.event_q = 1'b0;
		if (i_sample)
		begin
			next_st.low = ~st.stable;
			if (i_edge_mode)
				next_st.event_q = ~st.low & ~st.stable;
			else
				next_st.event_q = ~st.stable;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			st <= SMP_RESET;
		else
			st <= next_st;
	end

	assign o_event = st.event_q;
	assign o_low = st.low;

	a_edge_detect: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		i_sample && i_edge_mode && !st.low && !st.stable |=> o_event)
		else $error("high then low samples gave no edge event");

	a_level_detect: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		i_sample && !i_edge_mode |=> o_event == o_low)
		else $error("level sample and event disagree");

	a_edge_once: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		i_edge_mode && o_event |=> !o_event)
		else $error("edge event lasted more than one cycle");
endmodule

// >>> mic_pkg.sv
// constants and types shared by the interrupt controller files
package mic_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned CLKS_PER_INSTR = 4;
	localparam logic [1:0] LAST_PHASE = 2'(CLKS_PER_INSTR - 1);
	localparam int unsigned MIN_RESPONSE_INSTR = 5;
	localparam int unsigned MAX_RESPONSE_INSTR = 13;
	localparam int unsigned MAX_RESPONSE_CLKS =
		MAX_RESPONSE_INSTR * CLKS_PER_INSTR;
	localparam int unsigned STARTUP_TIME_NS = 1000;
	localparam int unsigned STARTUP_CYCLES =
		(STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STARTUP_W = 6;

	localparam logic [7:0] ADDR_EXT_EN = 8'he8;
	localparam logic [7:0] ADDR_EXT_PRIO = 8'hf8;
	localparam logic [7:0] ADDR_BASE_EN = 8'ha8;
	localparam logic [7:0] ADDR_BASE_PRIO = 8'hb8;
	localparam logic [7:0] ADDR_EXT_FLAG = 8'h91;
	localparam logic [7:0] ADDR_EXT_CTRL = 8'hd8;
	localparam logic [7:0] ADDR_CLK_CTRL = 8'hb6;

	localparam logic [2:0] RSVD_ONES = 3'h7;
	localparam int unsigned GLOBAL_EN_POS = 7;
	localparam int unsigned FLAG_LO_POS = 4;
	localparam int unsigned FLAG_ONE_POS = 3;
	localparam int unsigned WAKE_FLAG_POS = 3;
	localparam int unsigned CTRL_ONE_POS = 6;
	localparam int unsigned NUM_BASE = 6;
	localparam int unsigned NUM_SRC = 11;

	typedef enum logic [3:0] {
		SRC_EXT0,
		SRC_TMR0,
		SRC_EXT1,
		SRC_TMR1,
		SRC_SERIAL,
		SRC_TMR2,
		SRC_CONV_DONE,
		SRC_SPI_READY,
		SRC_DATA_READY,
		SRC_ADDR_MATCH,
		SRC_WAKEUP
	} mic_src_t;

	typedef struct packed {
		logic instr_end;
		logic is_return_from_irq;
	} mic_cpu_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
	} mic_sfr_t;

	typedef struct packed {
		logic req;
		logic high;
		mic_src_t src;
	} mic_irq_t;

	typedef struct packed {
		logic [2:0] sync;
		logic stable;
		logic low;
		logic event_q;
	} mic_smp_state_t;

	localparam mic_smp_state_t SMP_RESET = '{
		sync: 3'h7, stable: 1'b1, low: 1'b0, event_q: 1'b0};

	typedef struct packed {
		logic [1:0] phase;
		logic [4:0] ext_en;
		logic [4:0] ext_prio;
		logic [3:0] flag;
		logic wake_flag;
		logic [3:0] src_prev;
		logic [1:0] edge_pend;
		logic in_low;
		logic in_high;
		logic sfr_hold;
		logic win_valid;
		logic win_high;
		mic_src_t win_src;
		logic [7:0] rdata;
		logic rhit;
		logic power_down;
		logic waking;
		logic [STARTUP_W-1:0] start_cnt;
	} mic_ctl_state_t;

	localparam mic_ctl_state_t CTL_RESET = '0;
endpackage
